// file: shared/dcsd_consts.svh
// offsets, field positions, reset values and limits of the decade counter display block
`ifndef DCSD_CONSTS_SVH
`define DCSD_CONSTS_SVH
`define DCSD_NUM_DIGITS      4
`define DCSD_ADDR_W          8
`define DCSD_CTRL_OFS        8'h00
`define DCSD_COUNT_OFS       8'h04
`define DCSD_ISTAT_OFS       8'h08
`define DCSD_ICLR_OFS        8'h0c
`define DCSD_IEN_OFS         8'h10
`define DCSD_CTRL_MINSEC_BIT 0
`define DCSD_INT_W           2
`define DCSD_INT_ROLL_BIT    0
`define DCSD_INT_OVF_BIT     1
`define DCSD_DEC_MAX         4'h9
`define DCSD_TENS_MAX        4'h5
`define DCSD_RESP_OKAY       2'b00
`define DCSD_RESP_SLVERR     2'b10
`define DCSD_PIN_RST         6'h3f
`endif

// file: shared/dcsd_pkg.sv
// types of the decade counter display block
package dcsd_pkg;
   typedef logic [3:0] dcsd_digit_t;
   typedef logic [6:0] dcsd_seg_t;
   typedef enum logic [1:0] {
      DCSD_RD_IDLE = 2'b01,
      DCSD_RD_RESP = 2'b10
   } dcsd_rd_state_t;
endpackage

// file: hw/dcsd_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module dcsd_sync #(
   parameter int            W       = 1,
   parameter logic [W-1:0]  RST_VAL = '0
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   import dcsd_pkg::*;
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end

   always_comb begin
      q = q_r;
   end
endmodule
`default_nettype wire

// file: hw/dcsd_seg_decode.sv
// one decade to seven-segment decoder with blanking, segments {g,f,e,d,c,b,a}
`timescale 1ns/1ps
`default_nettype none
module dcsd_seg_decode (
   input  wire dcsd_pkg::dcsd_digit_t digit,
   input  wire logic                  blank,
   output var  dcsd_pkg::dcsd_seg_t   seg
);
   import dcsd_pkg::*;

   always_comb begin
      seg = 7'h00;
      if (!blank) begin
         case (digit)
            4'h0: seg = 7'h3f;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5b;
            4'h3: seg = 7'h4f;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6d;
            4'h6: seg = 7'h7d;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h6f;
            default: seg = 7'h40;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: hw/dcsd_top.sv
// four-decade counter with half digit, static segment drive and register access
// Notes on behaviour
// - four decades, each wrap advances the next
// - count on each synchronised falling input edge
// - rollover output falls after 9999 or 5959
// - rollover sets half-digit flop driving segment
// - half digit cleared only by counter reset
// - decades keep counting after half digit set
// - low tally hold stops the whole count
// - own seven-segment decoder for every decade
// - latches follow when load low, else hold
// - blank leading zeros when enabled, half clear
// - blanking off when input low or half set
// - cascade high only when all digits blanked
// - synchronised control inputs start high at reset
// - counter reset low forces 0000
// - twenty-nine static segment outputs, no multiplexing
// - display blank high turns all segments off
`timescale 1ns/1ps
`default_nettype none
`include "dcsd_consts.svh"
module dcsd_top (
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   input  wire logic                      count_in,
   input  wire logic                      tally_hold_b,
   input  wire logic                      latch_load_b,
   input  wire logic                      counter_reset_b,
   input  wire logic                      zero_suppress_in,
   input  wire logic                      display_blank,
   input  wire logic [`DCSD_ADDR_W-1:0]   axi_awaddr,
   input  wire logic                      axi_awvalid,
   output var  logic                      axi_awready,
   input  wire logic [31:0]               axi_wdata,
   input  wire logic [3:0]                axi_wstrb,
   input  wire logic                      axi_wvalid,
   output var  logic                      axi_wready,
   output var  logic [1:0]                axi_bresp,
   output var  logic                      axi_bvalid,
   input  wire logic                      axi_bready,
   input  wire logic [`DCSD_ADDR_W-1:0]   axi_araddr,
   input  wire logic                      axi_arvalid,
   output var  logic                      axi_arready,
   output var  logic [31:0]               axi_rdata,
   output var  logic [1:0]                axi_rresp,
   output var  logic                      axi_rvalid,
   input  wire logic                      axi_rready,
   output var  logic [28:0]               seg_out,
   output var  logic                      rollover_out,
   output var  logic                      zero_suppress_cascade_out,
   output var  logic                      irq
);
   import dcsd_pkg::*;

   localparam int ND = `DCSD_NUM_DIGITS;

   logic [5:0]                pin_s;
   logic                      cnt_s, hold_s, store_s, creset_s, zs_s, dblank_s;
   dcsd_digit_t [ND-1:0]      digit_r, digit_nxt, dig_step, dig_max;
   dcsd_seg_t   [ND-1:0]      dig_seg;
   logic [ND:0]               carry;
   logic [ND-1:0]             blank_chain, dig_zero;
   logic                      cnt_prev_r, half_r, half_nxt, roll_out_r, roll_out_nxt;
   logic                      cnt_fall, step, roll_evt, blank_en;
   logic [28:0]               seg_lat_r, seg_lat_nxt, seg_out_r, seg_out_nxt;
   logic                      casc_r, casc_nxt;
   logic [`DCSD_INT_W-1:0]    istat_r, istat_nxt, ien_r, ien_nxt, clr_bits, ev;
   logic                      irq_r, irq_nxt, minsec_r, minsec_nxt;
   logic                      aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [`DCSD_ADDR_W-1:0]   aw_addr_r, aw_addr_nxt;
   logic [31:0]               w_data_r, w_data_nxt, rdata_r, rdata_nxt;
   logic                      w_strb0_r, w_strb0_nxt;
   logic                      awready_r, awready_nxt, wready_r, wready_nxt;
   logic                      bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
   logic [1:0]                bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   dcsd_rd_state_t            rd_st_r, rd_st_nxt;

   // all pins pass a two-flop synchroniser
   // synchronised pins start high, the idle level
   dcsd_sync #(.W(6), .RST_VAL(`DCSD_PIN_RST)) u_sync (
      .clock (clock),
      .rst_b (rst_b),
      .d     ({display_blank, zero_suppress_in, counter_reset_b, latch_load_b, tally_hold_b, count_in}),
      .q     (pin_s)
   );
   assign {dblank_s, zs_s, creset_s, store_s, hold_s, cnt_s} = pin_s;

   assign cnt_fall = cnt_prev_r & ~cnt_s;
   // hold gates the first stage, edge tracking goes on
   assign step     = cnt_fall & hold_s;
   assign carry[0] = step;
   assign roll_evt = carry[ND];
   assign blank_en = zs_s & ~half_r;

   generate
      for (genvar i = 0; i < ND; i++) begin : g_dec
         assign dig_max[i]  = (minsec_r && ((i % 2) == 1)) ? `DCSD_TENS_MAX : `DCSD_DEC_MAX;
         // wrap at decade top ripples onward
         assign carry[i+1]  = carry[i] & (digit_r[i] >= dig_max[i]);
         assign dig_step[i] = carry[i+1] ? 4'h0 : (carry[i] ? digit_r[i] + 4'h1 : digit_r[i]);
         assign dig_zero[i] = (digit_r[i] == 4'h0);
         if (i == ND - 1) begin : g_msd
            assign blank_chain[i] = blank_en & dig_zero[i];
         end else begin : g_low
            assign blank_chain[i] = blank_chain[i+1] & dig_zero[i];
         end
         dcsd_seg_decode u_dec (
            .digit (digit_r[i]),
            .blank (blank_chain[i]),
            .seg   (dig_seg[i])
         );
      end
   endgenerate

   // counter core
   always_comb begin
      digit_nxt = dig_step;
      half_nxt  = half_r | roll_evt;
      // counter reset clears decades and half digit
      if (!creset_s) begin
         digit_nxt = '0;
         half_nxt  = 1'b0;
      end
      // top stage falls on its wrap to zero
      roll_out_nxt = minsec_r ? digit_nxt[ND-1][2] : digit_nxt[ND-1][3];
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         digit_r    <= '0;
         half_r     <= 1'b0;
         roll_out_r <= 1'b0;
         cnt_prev_r <= 1'b1;
      end else begin
         digit_r    <= digit_nxt;
         half_r     <= half_nxt;
         roll_out_r <= roll_out_nxt;
         cnt_prev_r <= cnt_s;
      end
   end

   // display latches and drive
   always_comb begin
      seg_lat_nxt = seg_lat_r;
      casc_nxt    = casc_r;
      // latches follow while load is low
      if (!store_s) begin
         seg_lat_nxt = {half_r, dig_seg};
         // cascade only when every digit blanked
         casc_nxt    = blank_chain[0];
      end
      seg_out_nxt = dblank_s ? 29'h0 : seg_lat_r;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         seg_lat_r <= '0;
         seg_out_r <= '0;
         casc_r    <= 1'b0;
      end else begin
         seg_lat_r <= seg_lat_nxt;
         seg_out_r <= seg_out_nxt;
         casc_r    <= casc_nxt;
      end
   end

   assign ev[`DCSD_INT_ROLL_BIT] = roll_evt;
   assign ev[`DCSD_INT_OVF_BIT]  = roll_evt & ~half_r & creset_s;

   // register slave and interrupt
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt  = w_hold_r;
      w_data_nxt  = w_data_r;
      w_strb0_nxt = w_strb0_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      minsec_nxt  = minsec_r;
      ien_nxt     = ien_r;
      clr_bits    = '0;
      rd_st_nxt   = rd_st_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (bvalid_r && axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (axi_awvalid && awready_r) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = axi_awaddr;
      end
      if (axi_wvalid && wready_r) begin
         w_hold_nxt  = 1'b1;
         w_data_nxt  = axi_wdata;
         w_strb0_nxt = axi_wstrb[0];
      end
      if (aw_hold_r && w_hold_r && !bvalid_r) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = `DCSD_RESP_OKAY;
         if ({aw_addr_r[7:2], 2'b00} == `DCSD_CTRL_OFS) begin
            if (w_strb0_r) minsec_nxt = w_data_r[`DCSD_CTRL_MINSEC_BIT];
         end else if ({aw_addr_r[7:2], 2'b00} == `DCSD_IEN_OFS) begin
            if (w_strb0_r) ien_nxt = w_data_r[`DCSD_INT_W-1:0];
         end else if ({aw_addr_r[7:2], 2'b00} == `DCSD_ICLR_OFS) begin
            if (w_strb0_r) clr_bits = w_data_r[`DCSD_INT_W-1:0];
         end else if ({aw_addr_r[7:2], 2'b00} == `DCSD_COUNT_OFS) begin
            bresp_nxt = `DCSD_RESP_OKAY;
         end else if ({aw_addr_r[7:2], 2'b00} == `DCSD_ISTAT_OFS) begin
            bresp_nxt = `DCSD_RESP_OKAY;
         end else begin
            bresp_nxt = `DCSD_RESP_SLVERR;
         end
      end
      awready_nxt = !aw_hold_nxt && !bvalid_nxt;
      wready_nxt  = !w_hold_nxt && !bvalid_nxt;
      case (rd_st_r)
         DCSD_RD_IDLE: begin
            if (axi_arvalid && arready_r) begin
               rd_st_nxt  = DCSD_RD_RESP;
               rvalid_nxt = 1'b1;
               rresp_nxt  = `DCSD_RESP_OKAY;
               rdata_nxt  = 32'h0;
               if ({axi_araddr[7:2], 2'b00} == `DCSD_CTRL_OFS) begin
                  rdata_nxt[`DCSD_CTRL_MINSEC_BIT] = minsec_r;
               end else if ({axi_araddr[7:2], 2'b00} == `DCSD_COUNT_OFS) begin
                  rdata_nxt = {15'h0, half_r, digit_r};
               end else if ({axi_araddr[7:2], 2'b00} == `DCSD_ISTAT_OFS) begin
                  rdata_nxt[`DCSD_INT_W-1:0] = istat_r;
               end else if ({axi_araddr[7:2], 2'b00} == `DCSD_IEN_OFS) begin
                  rdata_nxt[`DCSD_INT_W-1:0] = ien_r;
               end else if ({axi_araddr[7:2], 2'b00} == `DCSD_ICLR_OFS) begin
                  rdata_nxt = 32'h0;
               end else begin
                  rresp_nxt = `DCSD_RESP_SLVERR;
               end
            end
         end
         DCSD_RD_RESP: begin
            if (axi_rready) begin
               rd_st_nxt  = DCSD_RD_IDLE;
               rvalid_nxt = 1'b0;
            end
         end
         default: begin
            rd_st_nxt  = DCSD_RD_IDLE;
            rvalid_nxt = 1'b0;
         end
      endcase
      arready_nxt = (rd_st_nxt == DCSD_RD_IDLE);
      // a new event wins over a clear in the same cycle
      istat_nxt = (istat_r & ~clr_bits) | ev;
      irq_nxt   = |(istat_r & ien_r);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_hold_r  <= 1'b0;
         w_data_r  <= '0;
         w_strb0_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `DCSD_RESP_OKAY;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         minsec_r  <= 1'b0;
         ien_r     <= '0;
         istat_r   <= '0;
         irq_r     <= 1'b0;
         rd_st_r   <= DCSD_RD_IDLE;
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= `DCSD_RESP_OKAY;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r  <= w_hold_nxt;
         w_data_r  <= w_data_nxt;
         w_strb0_r <= w_strb0_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         minsec_r  <= minsec_nxt;
         ien_r     <= ien_nxt;
         istat_r   <= istat_nxt;
         irq_r     <= irq_nxt;
         rd_st_r   <= rd_st_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   assign axi_awready               = awready_r;
   assign axi_wready                = wready_r;
   assign axi_bvalid                = bvalid_r;
   assign axi_bresp                 = bresp_r;
   assign axi_arready               = arready_r;
   assign axi_rvalid                = rvalid_r;
   assign axi_rdata                 = rdata_r;
   assign axi_rresp                 = rresp_r;
   assign seg_out                   = seg_out_r;
   assign rollover_out              = roll_out_r;
   assign zero_suppress_cascade_out = casc_r;
   assign irq                       = irq_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence roll_seq;
      roll_evt ##1 $fell(roll_out_r);
   endsequence

   count_step_a: assert property (step && creset_s |=> digit_r[0] != $past(digit_r[0]))
      else $error("count did not advance on a falling edge");
   decade_wrap_a: assert property ((step && creset_s && digit_r[0] == `DCSD_DEC_MAX)
      |=> (digit_r[0] == 4'h0 && digit_r[1] != $past(digit_r[1])))
      else $error("decade wrap did not advance the next decade");
   hold_stop_a: assert property (!hold_s && creset_s |=> digit_r == $past(digit_r))
      else $error("count moved while held");
   reset_zero_a: assert property (!creset_s |=> (digit_r == '0 && !half_r))
      else $error("counter reset did not clear the count");
   roll_edge_a: assert property (roll_evt |-> roll_seq)
      else $error("rollover output did not fall after rollover");
   half_set_a: assert property (roll_evt && creset_s |=> half_r)
      else $error("half digit not set by rollover");
   half_sticky_a: assert property (half_r && creset_s |=> half_r)
      else $error("half digit lost without counter reset");
   latch_hold_a: assert property (store_s |=> $stable(seg_lat_r) && $stable(casc_r))
      else $error("segment latches changed while holding");
   cascade_low_a: assert property (!store_s && (!zs_s || half_r) |=> !casc_r)
      else $error("cascade output high with blanking disabled");
   blank_all_a: assert property (dblank_s |=> seg_out_r == 29'h0)
      else $error("segments driven while display blanked");
   irq_level_a: assert property (irq_r == $past(|(istat_r & ien_r)))
      else $error("interrupt does not follow enabled status");
endmodule
`default_nettype wire

// file: tb/dcsd_pulse_src.sv
// pulse source and cascade partner for the decade counter display block
`timescale 1ns/1ps
`default_nettype none
module dcsd_pulse_src (
   input  wire logic clock,
   input  wire logic cascade_in,
   output var  logic count_out,
   output var  logic next_zs_in
);
   initial count_out = 1'b1;
   assign next_zs_in = cascade_in;
   // upstream pulse train, two clocks low then two high
   task automatic burst(input int n);
      repeat (n) begin
         count_out <= 1'b0;
         repeat (2) @(posedge clock);
         count_out <= 1'b1;
         repeat (2) @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the decade counter display block
`timescale 1ns/1ps
`default_nettype none
`include "dcsd_consts.svh"
module testbench;
   logic        clock;
   logic        rst_b;
   logic        count_in;
   logic        tally_hold_b;
   logic        latch_load_b;
   logic        counter_reset_b;
   logic        zero_suppress_in;
   logic        display_blank;
   logic [7:0]  axi_awaddr;
   logic        axi_awvalid;
   logic        axi_awready;
   logic [31:0] axi_wdata;
   logic [3:0]  axi_wstrb;
   logic        axi_wvalid;
   logic        axi_wready;
   logic [1:0]  axi_bresp;
   logic        axi_bvalid;
   logic        axi_bready;
   logic [7:0]  axi_araddr;
   logic        axi_arvalid;
   logic        axi_arready;
   logic [31:0] axi_rdata;
   logic [1:0]  axi_rresp;
   logic        axi_rvalid;
   logic        axi_rready;
   logic [28:0] seg_out;
   logic        rollover_out;
   logic        cascade;
   logic        next_zs;
   logic        irq;
   int          err_count;
   int          checks;
   localparam logic [6:0] seg_tab [0:5] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d};

   dcsd_top i_dut (.clock(clock), .rst_b(rst_b), .count_in(count_in), .tally_hold_b(tally_hold_b),
      .latch_load_b(latch_load_b), .counter_reset_b(counter_reset_b), .zero_suppress_in(zero_suppress_in),
      .display_blank(display_blank), .axi_awaddr(axi_awaddr), .axi_awvalid(axi_awvalid),
      .axi_awready(axi_awready), .axi_wdata(axi_wdata), .axi_wstrb(axi_wstrb), .axi_wvalid(axi_wvalid),
      .axi_wready(axi_wready), .axi_bresp(axi_bresp), .axi_bvalid(axi_bvalid), .axi_bready(axi_bready),
      .axi_araddr(axi_araddr), .axi_arvalid(axi_arvalid), .axi_arready(axi_arready), .axi_rdata(axi_rdata),
      .axi_rresp(axi_rresp), .axi_rvalid(axi_rvalid), .axi_rready(axi_rready), .seg_out(seg_out),
      .rollover_out(rollover_out), .zero_suppress_cascade_out(cascade), .irq(irq));

   dcsd_pulse_src i_src (.clock(clock), .cascade_in(cascade), .count_out(count_in), .next_zs_in(next_zs));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic test_done();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask

   // handshakes are judged on settled values before the edge that takes them
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int         n;
      logic       aw_hit;
      logic       w_hit;
      logic       b_hit;
      logic [1:0] resp;
      axi_awaddr <= a;
      axi_wdata <= d;
      axi_awvalid <= 1'b1;
      axi_wvalid <= 1'b1;
      axi_bready <= 1'b1;
      b_hit = 1'b0;
      resp = 2'b11;
      for (n = 0; n < 50 && !b_hit; n++) begin
         @(negedge clock);
         aw_hit = axi_awvalid && axi_awready;
         w_hit = axi_wvalid && axi_wready;
         b_hit = axi_bvalid && axi_bready;
         resp = axi_bresp;
         @(posedge clock);
         if (aw_hit) axi_awvalid <= 1'b0;
         if (w_hit) axi_wvalid <= 1'b0;
      end
      axi_bready <= 1'b0;
      if (!b_hit) begin
         err_count++;
         test_done();
      end
      cmp("bresp", 32'h0, {30'h0, resp});
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int          n;
      logic        ar_hit;
      logic        r_hit;
      logic [31:0] data;
      logic [1:0]  resp;
      axi_araddr <= a;
      axi_arvalid <= 1'b1;
      axi_rready <= 1'b1;
      r_hit = 1'b0;
      data = 32'h0;
      resp = 2'b11;
      for (n = 0; n < 50 && !r_hit; n++) begin
         @(negedge clock);
         ar_hit = axi_arvalid && axi_arready;
         r_hit = axi_rvalid && axi_rready;
         data = axi_rdata;
         resp = axi_rresp;
         @(posedge clock);
         if (ar_hit) axi_arvalid <= 1'b0;
      end
      axi_rready <= 1'b0;
      if (!r_hit) begin
         err_count++;
         test_done();
      end
      cmp("rdata", exp, data);
      cmp("rresp", {30'h0, er}, {30'h0, resp});
      @(posedge clock);
   endtask

   initial begin
      err_count = 0;
      checks = 0;
      rst_b <= 1'b0;
      tally_hold_b <= 1'b1;
      latch_load_b <= 1'b0;
      counter_reset_b <= 1'b1;
      zero_suppress_in <= 1'b1;
      display_blank <= 1'b0;
      axi_awaddr <= 8'h00;
      axi_awvalid <= 1'b0;
      axi_wdata <= 32'h0;
      axi_wstrb <= 4'hf;
      axi_wvalid <= 1'b0;
      axi_bready <= 1'b0;
      axi_araddr <= 8'h00;
      axi_arvalid <= 1'b0;
      axi_rready <= 1'b0;
      idle(16);
      rst_b <= 1'b1;
      idle(6);
      rd(`DCSD_CTRL_OFS, 32'h0, `DCSD_RESP_OKAY);
      rd(`DCSD_COUNT_OFS, 32'h0, `DCSD_RESP_OKAY);
      rd(`DCSD_ISTAT_OFS, 32'h0, `DCSD_RESP_OKAY);
      rd(8'h40, 32'h0, `DCSD_RESP_SLVERR);
      cmp("seg", 32'h0, {3'h0, seg_out});
      cmp("cascade", 32'h1, {31'h0, cascade});
      cmp("next_zs", 32'h1, {31'h0, next_zs});
      axw(`DCSD_IEN_OFS, 32'h2);
      rd(`DCSD_IEN_OFS, 32'h2, `DCSD_RESP_OKAY);
      axi_wstrb <= 4'he;
      axw(`DCSD_IEN_OFS, 32'h1);
      axi_wstrb <= 4'hf;
      rd(`DCSD_IEN_OFS, 32'h2, `DCSD_RESP_OKAY);
      i_src.burst(12);
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h12, `DCSD_RESP_OKAY);
      cmp("seg", {4'h0, 14'h0, seg_tab[1], seg_tab[2]}, {3'h0, seg_out});
      cmp("cascade", 32'h0, {31'h0, cascade});
      latch_load_b <= 1'b1;
      idle(6);
      i_src.burst(3);
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h15, `DCSD_RESP_OKAY);
      cmp("seg", {4'h0, 14'h0, seg_tab[1], seg_tab[2]}, {3'h0, seg_out});
      latch_load_b <= 1'b0;
      zero_suppress_in <= 1'b0;
      idle(6);
      cmp("seg", {4'h0, seg_tab[0], seg_tab[0], seg_tab[1], seg_tab[5]}, {3'h0, seg_out});
      cmp("cascade", 32'h0, {31'h0, cascade});
      tally_hold_b <= 1'b0;
      idle(6);
      i_src.burst(5);
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h15, `DCSD_RESP_OKAY);
      tally_hold_b <= 1'b1;
      display_blank <= 1'b1;
      idle(6);
      cmp("seg", 32'h0, {3'h0, seg_out});
      display_blank <= 1'b0;
      counter_reset_b <= 1'b0;
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h0, `DCSD_RESP_OKAY);
      counter_reset_b <= 1'b1;
      zero_suppress_in <= 1'b1;
      axw(`DCSD_CTRL_OFS, 32'h1);
      idle(4);
      i_src.burst(3599);
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h5959, `DCSD_RESP_OKAY);
      cmp("rollover", 32'h1, {31'h0, rollover_out});
      cmp("irq", 32'h0, {31'h0, irq});
      i_src.burst(1);
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h10000, `DCSD_RESP_OKAY);
      cmp("rollover", 32'h0, {31'h0, rollover_out});
      rd(`DCSD_ISTAT_OFS, 32'h3, `DCSD_RESP_OKAY);
      cmp("irq", 32'h1, {31'h0, irq});
      cmp("seg", {4'h1, seg_tab[0], seg_tab[0], seg_tab[0], seg_tab[0]}, {3'h0, seg_out});
      cmp("cascade", 32'h0, {31'h0, cascade});
      axw(`DCSD_ICLR_OFS, 32'h3);
      idle(3);
      rd(`DCSD_ISTAT_OFS, 32'h0, `DCSD_RESP_OKAY);
      cmp("irq", 32'h0, {31'h0, irq});
      axw(`DCSD_CTRL_OFS, 32'h0);
      idle(4);
      i_src.burst(10000);
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h10000, `DCSD_RESP_OKAY);
      rd(`DCSD_ISTAT_OFS, 32'h1, `DCSD_RESP_OKAY);
      cmp("irq", 32'h0, {31'h0, irq});
      counter_reset_b <= 1'b0;
      idle(6);
      rd(`DCSD_COUNT_OFS, 32'h0, `DCSD_RESP_OKAY);
      test_done();
   end
endmodule
`default_nettype wire
